// ### eirq_pkg.sv
// Package for the external interrupt pin configuration block.
// Assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock.
package eirq_pkg;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [7:0] EIRQ_CFG_ADDR = 8'hE4;
  localparam logic [7:0] EIRQ_TMR_CTRL_ADDR = 8'h88;
  localparam logic [7:0] EIRQ_SKIP_ADDR = 8'hE0;
  localparam logic [7:0] EIRQ_VEC_ADDR = 8'hEC;

  // Configuration register field positions and reset value.
  localparam int EIRQ_B_POL_BIT = 7;
  localparam int EIRQ_B_SEL_LSB = 4;
  localparam int EIRQ_A_POL_BIT = 3;
  localparam int EIRQ_A_SEL_LSB = 0;
  localparam logic [7:0] EIRQ_CFG_RST = 8'h01;

  // Timer control register field positions.
  localparam int EIRQ_A_TYPE_BIT = 0;
  localparam int EIRQ_A_PEND_BIT = 1;
  localparam int EIRQ_B_TYPE_BIT = 2;
  localparam int EIRQ_B_PEND_BIT = 3;
  localparam logic [7:0] EIRQ_TMR_CTRL_RST = 8'h00;
  localparam logic [7:0] EIRQ_SKIP_RST = 8'h00;

  // Bus response codes.
  localparam logic [1:0] EIRQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] EIRQ_RESP_SLVERR = 2'h2;

  // Write channel states.
  typedef enum logic [2:0] {
    EIRQ_W_IDLE = 3'b001,
    EIRQ_W_COLLECT = 3'b010,
    EIRQ_W_RESP = 3'b100
  } eirq_wstate_t;

endpackage : eirq_pkg

// ### eirq_channel.sv
// One external interrupt channel: pin select, polarity, sync, pending.
// Assumes port pins are synchronous inputs and the CPU vector ack is a pulse.
module eirq_channel
  import eirq_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Port pins and configuration.
  input wire logic [7:0] port_pins,
  input wire logic [2:0] pin_select,
  input wire logic polarity,
  input wire logic trigger_type,
  // Pending flag control.
  input wire logic vector_ack,
  input wire logic sw_write,
  input wire logic sw_value,
  output logic pending
);

  logic sync1_q, sync1_d;
  logic sync2_q, sync2_d;
  logic prev_q, prev_d;
  logic edge_q, edge_d;
  logic active;

  // The pin is only read here, so any crossbar owner keeps driving it.
  assign active = ~(sync2_q ^ polarity);

  // Two-stage synchroniser; only the second stage feeds the detector.
  always_comb begin
    sync1_d = port_pins[pin_select];
    sync2_d = sync1_q;
    prev_d = active;
    edge_d = edge_q;
    if (vector_ack) begin
      edge_d = 1'b0;
    end
    if (sw_write) begin
      edge_d = sw_value;
    end
    if (trigger_type && active && !prev_q) begin
      edge_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      edge_q <= edge_d;
    end
  end

  // Level mode follows the pin; a source held active re-requests.
  assign pending = trigger_type ? edge_q : active;

endmodule : eirq_channel

// ### eirq_top.sv
// Top of the external interrupt pin configuration block with AXI4-Lite.
// Assumes the CPU pulses vector acks and port pins are synchronous.
// Registers are one byte each, carried in lane 0 of the 32-bit bus.
// Contract
// - Bit 7 sets second input polarity.
// - Bit 3 sets first input polarity.
// - Trigger bit picks edge or level.
// - Bits 6:4 pick second input's pin.
// - Bits 2:0 pick first input's pin.
// - Inputs monitor pins without disturbing crossbar.
// - Skipped pins get no crossbar peripheral.
// - Pending flags at timer control bits 1, 3.
// - Edge pending clears when CPU vectors.
// - Level pending follows active input directly.
//
// The AXI4-Lite slave port was left to the implementer.
module eirq_top
  import eirq_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port 0 pins and CPU vector acknowledges.
  input wire logic [7:0] port0_pins,
  input wire logic vector_ack_a,
  input wire logic vector_ack_b,
  // Interrupt requests and crossbar pin permissions.
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic [7:0] crossbar_pin_allow
);

  //////////////////////////////////////////////////////////////////////////
  // Registers.

  // Software-visible state: pin configuration, crossbar skip mask and the
  // two trigger-type bits that live in the timer control word.
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] skip_q, skip_d;
  logic type_a_q, type_a_d;
  logic type_b_q, type_b_d;
  logic irq_a_pending, irq_b_pending;
  logic tmr_ctrl_wr;

  // Write channel bookkeeping: the address and data beats may arrive in
  // either order, so each is parked until its partner shows up.
  eirq_wstate_t wst_q, wst_d;
  logic [7:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic wstrb_q, wstrb_d;
  logic have_aw_q, have_aw_d;
  logic have_w_q, have_w_d;
  logic [1:0] bresp_q, bresp_d;
  // Read answer, held until the master takes it.
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic wr_fire;

  //////////////////////////////////////////////////////////////////////////
  // Write channel: collect address and data in either order.

  assign s_axi_awready = (wst_q != EIRQ_W_RESP) && !have_aw_q;
  assign s_axi_wready = (wst_q != EIRQ_W_RESP) && !have_w_q;
  assign s_axi_bvalid = (wst_q == EIRQ_W_RESP);
  assign s_axi_bresp = bresp_q;

  // Next-state logic for the write side. A beat is taken only when its
  // valid and ready meet; the register write fires in the cycle in which
  // the second beat arrives, so the new value is visible one edge later.
  // Unmapped addresses still complete, with an error response, so that a
  // stray write can never hang the bus.
  always_comb begin
    wst_d = wst_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    have_aw_d = have_aw_q;
    have_w_d = have_w_q;
    bresp_d = bresp_q;
    wr_fire = 1'b0;
    case (wst_q)
      EIRQ_W_IDLE, EIRQ_W_COLLECT: begin
        if (s_axi_awvalid && s_axi_awready) begin
          waddr_d = s_axi_awaddr;
          have_aw_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wdata_d = s_axi_wdata[7:0];
          wstrb_d = s_axi_wstrb[0];
          have_w_d = 1'b1;
        end
        if (have_aw_d && have_w_d) begin
          wr_fire = 1'b1;
          have_aw_d = 1'b0;
          have_w_d = 1'b0;
          wst_d = EIRQ_W_RESP;
          case (waddr_d)
            EIRQ_CFG_ADDR, EIRQ_TMR_CTRL_ADDR, EIRQ_SKIP_ADDR:
              bresp_d = EIRQ_RESP_OKAY;
            default: bresp_d = EIRQ_RESP_SLVERR;
          endcase
        end else if (have_aw_d || have_w_d) begin
          wst_d = EIRQ_W_COLLECT;
        end
      end
      EIRQ_W_RESP: begin
        if (s_axi_bready) begin
          wst_d = EIRQ_W_IDLE;
        end
      end
      default: wst_d = EIRQ_W_IDLE;
    endcase
  end

  // Write side state. Reset leaves both ready signals high and no
  // response pending, so the first request may come at the first edge
  // after reset is released.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wst_q <= EIRQ_W_IDLE;
      waddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      bresp_q <= EIRQ_RESP_OKAY;
    end else begin
      wst_q <= wst_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      have_aw_q <= have_aw_d;
      have_w_q <= have_w_d;
      bresp_q <= bresp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register updates; only byte lane 0 carries data.

  // A write to the timer control word also reaches the two pending flags,
  // which is why it is decoded once here and handed to both channels.
  // A cleared lane 0 strobe drops the write but still answers OKAY.
  assign tmr_ctrl_wr = wr_fire && wstrb_d &&
                       (waddr_d == EIRQ_TMR_CTRL_ADDR);

  // Next values of the configuration, skip and trigger-type registers.
  // Only the low byte matters; the upper lanes are ignored on purpose so
  // that a word-wide store from software behaves like a byte store.
  always_comb begin
    cfg_d = cfg_q;
    skip_d = skip_q;
    type_a_d = type_a_q;
    type_b_d = type_b_q;
    if (wr_fire && wstrb_d) begin
      if (waddr_d == EIRQ_CFG_ADDR) begin
        cfg_d = wdata_d;
      end
      if (waddr_d == EIRQ_SKIP_ADDR) begin
        skip_d = wdata_d;
      end
      if (tmr_ctrl_wr) begin
        type_a_d = wdata_d[EIRQ_A_TYPE_BIT];
        type_b_d = wdata_d[EIRQ_B_TYPE_BIT];
      end
    end
  end

  // Register bank. After reset both inputs are level sensitive and active
  // low, so an idle low pin reads as a pending request until software
  // reprograms the polarity; firmware must expect that.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_q <= EIRQ_CFG_RST;
      skip_q <= EIRQ_SKIP_RST;
      type_a_q <= EIRQ_TMR_CTRL_RST[EIRQ_A_TYPE_BIT];
      type_b_q <= EIRQ_TMR_CTRL_RST[EIRQ_B_TYPE_BIT];
    end else begin
      cfg_q <= cfg_d;
      skip_q <= skip_d;
      type_a_q <= type_a_d;
      type_b_q <= type_b_d;
    end
  end

  // A skipped pin is withheld from crossbar peripherals. The interrupt
  // channels read the pins whatever this mask says, so skipping a pin only
  // keeps other peripherals off it.
  assign crossbar_pin_allow = ~skip_q;

  //////////////////////////////////////////////////////////////////////////
  // The two interrupt channels.

  // Channel A watches the pin picked by the low field of the configuration
  // register. Both channels see the full port so that either can pick any
  // pin, even the same one; each keeps its own synchroniser.
  eirq_channel u_chan_a (
    .core_clk(core_clk),
    .srst(srst),
    .port_pins(port0_pins),
    .pin_select(cfg_q[EIRQ_A_SEL_LSB +: 3]),
    .polarity(cfg_q[EIRQ_A_POL_BIT]),
    .trigger_type(type_a_q),
    .vector_ack(vector_ack_a),
    .sw_write(tmr_ctrl_wr),
    .sw_value(wdata_d[EIRQ_A_PEND_BIT]),
    .pending(irq_a_pending)
  );

  // Channel B uses the high field. It shares the timer control write
  // strobe with channel A; each takes its own pending bit of the data.
  eirq_channel u_chan_b (
    .core_clk(core_clk),
    .srst(srst),
    .port_pins(port0_pins),
    .pin_select(cfg_q[EIRQ_B_SEL_LSB +: 3]),
    .polarity(cfg_q[EIRQ_B_POL_BIT]),
    .trigger_type(type_b_q),
    .vector_ack(vector_ack_b),
    .sw_write(tmr_ctrl_wr),
    .sw_value(wdata_d[EIRQ_B_PEND_BIT]),
    .pending(irq_b_pending)
  );

  // Requests to the CPU are the pending flags themselves. There is no
  // extra register, so a level-mode request drops as soon as the
  // synchronised pin does.
  assign ext_irq_a = irq_a_pending;
  assign ext_irq_b = irq_b_pending;

  //////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answered the cycle after address.

  // Only one read is in flight; a new address waits until the previous
  // answer has been taken, which keeps the read data stable while shown.
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Read decode. Pending bits are sampled as the address is taken, so a
  // level-mode flag that drops later still reads as it stood then.
  // Unmapped offsets read zero with an error response.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rdata_d = 32'h0000_0000;
      rresp_d = EIRQ_RESP_OKAY;
      case (s_axi_araddr)
        EIRQ_CFG_ADDR: rdata_d[7:0] = cfg_q;
        EIRQ_SKIP_ADDR: rdata_d[7:0] = skip_q;
        EIRQ_TMR_CTRL_ADDR: begin
          rdata_d[EIRQ_A_TYPE_BIT] = type_a_q;
          rdata_d[EIRQ_A_PEND_BIT] = irq_a_pending;
          rdata_d[EIRQ_B_TYPE_BIT] = type_b_q;
          rdata_d[EIRQ_B_PEND_BIT] = irq_b_pending;
        end
        default: rresp_d = EIRQ_RESP_SLVERR;
      endcase
    end
  end

  // Read answer registers. Reset drops any answer that was on its way,
  // so a master must not reset the block in the middle of a read.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= EIRQ_RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

endmodule : eirq_top

// ### eirq_properties.sv
// Checker for the bus handshakes and crossbar outputs of eirq_top.
// Assumes it is bound to eirq_top and sees only its ports.
module eirq_properties (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Write channels.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels.
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Crossbar permissions.
  input wire logic [7:0] crossbar_pin_allow
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////
  // A request is taken when its valid and ready meet at an edge.
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_reset_state;
    $fell(srst) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid
      && !s_axi_rvalid;
  endproperty
  property p_reset_allow;
    $fell(srst) |-> crossbar_pin_allow == 8'hFF;
  endproperty
  // Pin traffic must never move the crossbar; only a write may.
  property p_allow_write;
    !$stable(crossbar_pin_allow) |-> $rose(s_axi_bvalid);
  endproperty
  property p_write_resp;
    s_wr_taken |=> s_axi_bvalid;
  endproperty
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_read_resp;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_no_take_in_resp;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Bus not idle after reset.");
  a_reset_allow: assert property (p_reset_allow)
    else $error("Crossbar allow not all ones after reset.");
  a_allow_write: assert property (p_allow_write)
    else $error("Crossbar allow changed without a write.");
  a_write_resp: assert property (p_write_resp)
    else $error("Write response missing.");
  a_b_stands: assert property (p_b_stands)
    else $error("Write response dropped early.");
  a_read_resp: assert property (p_read_resp)
    else $error("Read response missing.");
  a_r_stands: assert property (p_r_stands)
    else $error("Read data dropped early.");
  a_no_take_in_resp: assert property (p_no_take_in_resp)
    else $error("Write taken during response.");
endmodule // eirq_properties

// ### eirq_pin_src.sv
// Model of the external sources that drive the port 0 pins.
// Assumes the bench requests levels; pins change just after an edge.
module eirq_pin_src (
  // Clock.
  input wire logic core_clk,
  // Requested levels and driven pins.
  input wire logic [7:0] level_req,
  output logic [7:0] port0_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pins_q = 8'h00;
  // Each level is held for whole cycles until the bench releases it.
  always @(posedge core_clk) begin
    pins_q <= level_req;
  end
  assign port0_pins = pins_q;
endmodule // eirq_pin_src

// ### tb_external_interrupt_pin_config.sv
// Self-checking bench for eirq_top with a pin source model.
// Assumes eirq_pkg, eirq_top, eirq_pin_src and the checker are compiled.
module tb_external_interrupt_pin_config;
  import eirq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [1:0] resp;
    logic [7:0] rd;
  } eirq_row_t;
  logic core_clk = 1'h0;
  logic srst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, level_req = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic vector_ack_a = 1'h0, vector_ack_b = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ext_irq_a, ext_irq_b;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] port0_pins, crossbar_pin_allow;
  int fails = 0, total_checks = 0;
  // Reset values, then write and read back; the last place is unmapped.
  eirq_row_t rows [6] = '{
    '{1'h0, EIRQ_CFG_ADDR, 8'h00, EIRQ_RESP_OKAY, 8'h01},
    '{1'h0, EIRQ_TMR_CTRL_ADDR, 8'h00, EIRQ_RESP_OKAY, 8'h0A},
    '{1'h0, EIRQ_SKIP_ADDR, 8'h00, EIRQ_RESP_OKAY, 8'h00},
    '{1'h1, EIRQ_CFG_ADDR, 8'hA5, EIRQ_RESP_OKAY, 8'hA5},
    '{1'h1, EIRQ_SKIP_ADDR, 8'h3C, EIRQ_RESP_OKAY, 8'h3C},
    '{1'h1, EIRQ_VEC_ADDR, 8'h11, EIRQ_RESP_SLVERR, 8'h00}};
  eirq_top uut (.*);
  eirq_pin_src u_src (.core_clk, .level_req, .port0_pins);
  //////////////////////////////////////////////////////////////
  // Clock of 8 ns.
  always #4 core_clk = ~core_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Requests change just after an edge and stand until their ready is
  // seen at a rising edge; the answer is taken at the edge it shows.
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    // One idle edge keeps a following call off the signals just lowered.
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic end_sim;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    fails++;
    end_sim;
  end
  // Table first, then pin behaviour and a second reset.
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    cyc(3);
    srst <= 1'h0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].data, r);
        chk(r, rows[i].resp);
      end
      rd(rows[i].addr, d, r);
      chk(d, rows[i].rd);
      chk(r, rows[i].resp);
      if (rows[i].addr == EIRQ_SKIP_ADDR)
        chk({24'h0, crossbar_pin_allow}, {24'h0, ~rows[i].rd});
    end
    for (int s = 0; s < 8; s++) begin
      wr(EIRQ_CFG_ADDR, {1'h1, 3'(s), 1'h0, 3'(7 - s)}, r);
      level_req <= 8'h01 << s;
      cyc(4);
      chk({ext_irq_b, ext_irq_a}, 2'h3);
      rd(EIRQ_TMR_CTRL_ADDR, d, r);
      chk(d, 32'h0A);
      level_req <= ~(8'h01 << s);
      cyc(4);
      chk({ext_irq_b, ext_irq_a}, 2'h0);
    end
    level_req <= 8'h02;
    wr(EIRQ_CFG_ADDR, 8'h18, r);
    wr(EIRQ_TMR_CTRL_ADDR, 8'h05, r);
    cyc(4);
    chk({ext_irq_b, ext_irq_a}, 2'h0);
    level_req <= 8'h03;
    // Edge pending lands one edge after the second synchroniser stage.
    cyc(5);
    chk({ext_irq_b, ext_irq_a}, 2'h1);
    level_req <= 8'h02;
    cyc(4);
    chk({ext_irq_b, ext_irq_a}, 2'h1);
    vector_ack_a <= 1'h1;
    cyc(1);
    vector_ack_a <= 1'h0;
    cyc(1);
    chk({ext_irq_b, ext_irq_a}, 2'h0);
    level_req <= 8'h00;
    cyc(4);
    rd(EIRQ_TMR_CTRL_ADDR, d, r);
    chk(d, 32'h0D);
    vector_ack_b <= 1'h1;
    cyc(1);
    vector_ack_b <= 1'h0;
    cyc(1);
    chk({ext_irq_b, ext_irq_a}, 2'h0);
    // A write with the lane 0 strobe low is dropped but answered OKAY.
    s_axi_wstrb <= 4'h0;
    wr(EIRQ_CFG_ADDR, 8'h55, r);
    chk(r, EIRQ_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(EIRQ_CFG_ADDR, d, r);
    chk(d, 32'h18);
    srst <= 1'h1;
    cyc(3);
    srst <= 1'h0;
    rd(EIRQ_CFG_ADDR, d, r);
    chk(d, 32'h01);
    chk({24'h0, crossbar_pin_allow}, 32'hFF);
    end_sim;
  end
endmodule // tb_external_interrupt_pin_config
bind eirq_top eirq_properties u_props (.*);
